// >>> serial_mp_port.sv
// Purpose: Asynchronous serial transmitter and receiver with multidrop addressing
// Assumes: Control bits arrive as plain ports on the system clock; line input is asynchronous
// Notes: Data-available and error status bits clear through one-cycle pulses from the processor side
`timescale 1ns/1ps
`default_nettype none
module serial_mp_port (
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic CLK_EN_IN,
   input wire serial_mp_pkg::ctrl_s CTRL_IN,
   input wire logic [7:0] TX_DATA_IN,
   input wire logic TX_WRITE_IN,
   input wire logic RX_READ_IN,
   input wire logic ERR_CLEAR_IN,
   input wire logic SERIAL_RX_IN,
   output logic SERIAL_TX_OUT,
   output logic [7:0] RX_DATA_OUT,
   output serial_mp_pkg::status_s STATUS_OUT,
   output logic TX_IRQ_OUT,
   output logic RX_IRQ_OUT
);
   function automatic logic parity_of(input logic [7:0] d, input logic odd);
      parity_of = ^d ^ odd;
   endfunction

   // Baud tick generator, shared by both directions
   logic [15:0] div_cnt_r, div_cnt_nxt;
   logic tick;
   logic [15:0] divisor;
   assign divisor = {CTRL_IN.baud_divisor_hi, CTRL_IN.baud_divisor_lo};
   assign tick = (div_cnt_r == 16'h0000);
   always_comb begin
      if (tick) begin
         // Divisor zero is treated as one to keep the tick alive
         div_cnt_nxt = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
      end else begin
         div_cnt_nxt = div_cnt_r - 16'h0001;
      end
   end
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_B_IN) begin
         div_cnt_r <= 16'h0000;
      end else if (CLK_EN_IN) begin
         div_cnt_r <= div_cnt_nxt;
      end
   end

   // Transmitter
   serial_mp_pkg::tx_state_e tx_st_r, tx_st_nxt;
   logic [7:0] hold_r, hold_nxt, shift_r, shift_nxt;
   logic hold_full_r, hold_full_nxt, ninth_r, ninth_nxt, has_ninth_r, has_ninth_nxt;
   logic [3:0] tx_ovs_r, tx_ovs_nxt, tx_bit_r, tx_bit_nxt;
   logic tx_line_r, tx_line_nxt;
   always_comb begin
      tx_st_nxt = tx_st_r;
      hold_nxt = hold_r;
      shift_nxt = shift_r;
      hold_full_nxt = hold_full_r;
      ninth_nxt = ninth_r;
      has_ninth_nxt = has_ninth_r;
      tx_ovs_nxt = tx_ovs_r;
      tx_bit_nxt = tx_bit_r;
      tx_line_nxt = tx_line_r;
      if (TX_WRITE_IN && !hold_full_r) begin
         hold_nxt = TX_DATA_IN;
         hold_full_nxt = 1'b1;
      end
      if (tick) begin
         tx_ovs_nxt = tx_ovs_r + 4'h1;
      end
      case (tx_st_r)
         serial_mp_pkg::TX_IDLE: begin
            tx_line_nxt = 1'b1;
            if (hold_full_r) begin
               shift_nxt = hold_r;
               hold_full_nxt = 1'b0;
               has_ninth_nxt = CTRL_IN.multidrop_enable | CTRL_IN.parity_enable;
               ninth_nxt = CTRL_IN.multidrop_enable ? CTRL_IN.tx_addr_flag_bit
                  : parity_of(hold_r, CTRL_IN.parity_odd);
               tx_ovs_nxt = 4'h0;
               tx_line_nxt = 1'b0;
               tx_st_nxt = serial_mp_pkg::TX_START;
            end
         end
         serial_mp_pkg::TX_START: begin
            if (tick && tx_ovs_r == serial_mp_pkg::OVS_LAST) begin
               tx_line_nxt = shift_r[0];
               tx_bit_nxt = 4'h0;
               tx_st_nxt = serial_mp_pkg::TX_DATA;
            end
         end
         serial_mp_pkg::TX_DATA: begin
            if (tick && tx_ovs_r == serial_mp_pkg::OVS_LAST) begin
               tx_bit_nxt = tx_bit_r + 4'h1;
               if (tx_bit_r == serial_mp_pkg::DATA_LAST + {3'h0, has_ninth_r}) begin
                  tx_line_nxt = 1'b1;
                  tx_st_nxt = serial_mp_pkg::TX_STOP;
               end else if (tx_bit_r == serial_mp_pkg::DATA_LAST) begin
                  tx_line_nxt = ninth_r;
               end else begin
                  shift_nxt = {1'b1, shift_r[7:1]};
                  tx_line_nxt = shift_r[1];
               end
            end
         end
         serial_mp_pkg::TX_STOP: begin
            if (tick && tx_ovs_r == serial_mp_pkg::OVS_LAST) begin
               tx_st_nxt = serial_mp_pkg::TX_IDLE;
            end
         end
         default: tx_st_nxt = serial_mp_pkg::TX_IDLE;
      endcase
   end
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_B_IN) begin
         tx_st_r <= serial_mp_pkg::TX_IDLE;
         hold_r <= 8'h00;
         shift_r <= 8'h00;
         hold_full_r <= 1'b0;
         ninth_r <= 1'b0;
         has_ninth_r <= 1'b0;
         tx_ovs_r <= 4'h0;
         tx_bit_r <= 4'h0;
         tx_line_r <= 1'b1;
      end else if (CLK_EN_IN) begin
         tx_st_r <= tx_st_nxt;
         hold_r <= hold_nxt;
         shift_r <= shift_nxt;
         hold_full_r <= hold_full_nxt;
         ninth_r <= ninth_nxt;
         has_ninth_r <= has_ninth_nxt;
         tx_ovs_r <= tx_ovs_nxt;
         tx_bit_r <= tx_bit_nxt;
         tx_line_r <= tx_line_nxt;
      end
   end
   assign SERIAL_TX_OUT = tx_line_r;

   // Line synchroniser; only the second stage is looked at
   logic rx_meta_r, rx_sync_r;
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_B_IN) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else if (CLK_EN_IN) begin
         rx_meta_r <= SERIAL_RX_IN;
         rx_sync_r <= rx_meta_r;
      end
   end

   // Receiver
   serial_mp_pkg::rx_state_e rx_st_r, rx_st_nxt;
   logic [7:0] rx_shift_r, rx_shift_nxt, rx_data_r, rx_data_nxt;
   logic [3:0] rx_ovs_r, rx_ovs_nxt, rx_bit_r, rx_bit_nxt;
   logic rx_ninth_r, rx_ninth_nxt, rx_all0_r, rx_all0_nxt, selected_r, selected_nxt;
   serial_mp_pkg::status_s st_r, st_nxt;
   logic mid, accept, is_addr, matched;
   assign mid = tick && rx_ovs_r == serial_mp_pkg::OVS_MID;
   assign is_addr = CTRL_IN.multidrop_enable && rx_ninth_r;
   assign matched = rx_shift_r == CTRL_IN.match_address;
   always_comb begin
      // Decides whether a finished frame is delivered to software
      accept = 1'b1;
      if (CTRL_IN.multidrop_enable) begin
         case (CTRL_IN.addr_match_scheme)
            serial_mp_pkg::SCHEME_NONE: accept = 1'b1;
            serial_mp_pkg::SCHEME_ADDR_ONLY: accept = is_addr;
            serial_mp_pkg::SCHEME_MATCH_DATA: accept = is_addr ? 1'b0 : selected_r;
            serial_mp_pkg::SCHEME_MATCH_ALL: accept = is_addr ? matched : selected_r;
            default: accept = 1'b1;
         endcase
      end
   end
   always_comb begin
      rx_st_nxt = rx_st_r;
      rx_shift_nxt = rx_shift_r;
      rx_data_nxt = rx_data_r;
      rx_ovs_nxt = tick ? rx_ovs_r + 4'h1 : rx_ovs_r;
      rx_bit_nxt = rx_bit_r;
      rx_ninth_nxt = rx_ninth_r;
      rx_all0_nxt = rx_all0_r;
      selected_nxt = selected_r;
      st_nxt = st_r;
      // Next values, so the flags drop on the very edge that takes a write or starts a frame
      st_nxt.tx_hold_empty = !hold_full_nxt;
      st_nxt.tx_shift_empty = (tx_st_nxt == serial_mp_pkg::TX_IDLE);
      // Clears first so a same-cycle event below wins
      if (RX_READ_IN) begin
         st_nxt.rx_data_avail_flag = 1'b0;
      end
      if (ERR_CLEAR_IN) begin
         st_nxt.parity_error = 1'b0;
         st_nxt.overrun_error = 1'b0;
         st_nxt.framing_error = 1'b0;
         st_nxt.break_seen = 1'b0;
      end
      case (rx_st_r)
         serial_mp_pkg::RX_IDLE: begin
            if (!rx_sync_r && CTRL_IN.rx_enable) begin
               rx_ovs_nxt = 4'h0;
               rx_st_nxt = serial_mp_pkg::RX_START;
            end
         end
         serial_mp_pkg::RX_START: begin
            if (mid) begin
               // Glitch shorter than half a bit is rejected
               rx_st_nxt = rx_sync_r ? serial_mp_pkg::RX_IDLE : serial_mp_pkg::RX_DATA;
               rx_bit_nxt = 4'h0;
               rx_all0_nxt = 1'b1;
            end
         end
         serial_mp_pkg::RX_DATA: begin
            if (mid) begin
               rx_shift_nxt = {rx_sync_r, rx_shift_r[7:1]};
               rx_all0_nxt = rx_all0_r & !rx_sync_r;
               rx_bit_nxt = rx_bit_r + 4'h1;
               rx_ninth_nxt = 1'b0;
               if (rx_bit_r == serial_mp_pkg::DATA_LAST) begin
                  rx_st_nxt = (CTRL_IN.multidrop_enable | CTRL_IN.parity_enable)
                     ? serial_mp_pkg::RX_NINTH : serial_mp_pkg::RX_STOP;
               end
            end
         end
         serial_mp_pkg::RX_NINTH: begin
            if (mid) begin
               rx_ninth_nxt = rx_sync_r;
               rx_all0_nxt = rx_all0_r & !rx_sync_r;
               rx_st_nxt = serial_mp_pkg::RX_STOP;
            end
         end
         serial_mp_pkg::RX_STOP: begin
            if (mid) begin
               rx_st_nxt = serial_mp_pkg::RX_IDLE;
               if (!rx_sync_r) begin
                  st_nxt.framing_error = 1'b1;
                  st_nxt.break_seen = rx_all0_r | st_r.break_seen;
               end
               if (!CTRL_IN.multidrop_enable && CTRL_IN.parity_enable &&
                   rx_ninth_r != parity_of(rx_shift_r, CTRL_IN.parity_odd)) begin
                  st_nxt.parity_error = 1'b1;
               end
               if (is_addr) begin
                  selected_nxt = matched;
               end
               if (accept) begin
                  if (st_r.rx_data_avail_flag && !RX_READ_IN) begin
                     st_nxt.overrun_error = 1'b1;
                  end
                  rx_data_nxt = rx_shift_r;
                  st_nxt.rx_ninth_bit = rx_ninth_r;
                  st_nxt.rx_data_avail_flag = 1'b1;
               end
            end
         end
         default: rx_st_nxt = serial_mp_pkg::RX_IDLE;
      endcase
   end
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_B_IN) begin
         rx_st_r <= serial_mp_pkg::RX_IDLE;
         rx_shift_r <= 8'h00;
         rx_data_r <= 8'h00;
         rx_ovs_r <= 4'h0;
         rx_bit_r <= 4'h0;
         rx_ninth_r <= 1'b0;
         rx_all0_r <= 1'b0;
         selected_r <= 1'b0;
         st_r <= '{tx_hold_empty: 1'b1, tx_shift_empty: 1'b1, default: 1'b0};
      end else if (CLK_EN_IN) begin
         rx_st_r <= rx_st_nxt;
         rx_shift_r <= rx_shift_nxt;
         rx_data_r <= rx_data_nxt;
         rx_ovs_r <= rx_ovs_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_ninth_r <= rx_ninth_nxt;
         rx_all0_r <= rx_all0_nxt;
         selected_r <= selected_nxt;
         st_r <= st_nxt;
      end
   end
   assign RX_DATA_OUT = rx_data_r;
   assign STATUS_OUT = st_r;
   assign TX_IRQ_OUT = st_r.tx_hold_empty;
   assign RX_IRQ_OUT = st_r.parity_error | st_r.overrun_error | st_r.framing_error |
      st_r.break_seen | (st_r.rx_data_avail_flag & !CTRL_IN.irq_errors_only);
endmodule
`default_nettype wire

// >>> serial_mp_pkg.sv
// Purpose: Shared constants and carrier types for the multidrop serial port
// Assumes: One system clock, frames of start, eight data, optional ninth bit, one stop
// Notes: Divisor is sixteen bits, split into high and low byte ports
package serial_mp_pkg;
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] OVS_LAST = 4'hF;
   localparam logic [3:0] OVS_MID = 4'h7;
   localparam logic [3:0] DATA_LAST = 4'h7;
   localparam logic [15:0] DIVISOR_RESET = 16'h0001;
   localparam logic [1:0] SCHEME_NONE = 2'h0;
   localparam logic [1:0] SCHEME_ADDR_ONLY = 2'h1;
   localparam logic [1:0] SCHEME_MATCH_DATA = 2'h2;
   localparam logic [1:0] SCHEME_MATCH_ALL = 2'h3;

   typedef struct packed {
      logic rx_enable;
      logic parity_enable;
      logic parity_odd;
      logic multidrop_enable;
      logic [1:0] addr_match_scheme;
      logic tx_addr_flag_bit;
      logic irq_errors_only;
      logic [7:0] match_address;
      logic [7:0] baud_divisor_hi;
      logic [7:0] baud_divisor_lo;
   } ctrl_s;

   typedef struct packed {
      logic rx_data_avail_flag;
      logic parity_error;
      logic overrun_error;
      logic framing_error;
      logic break_seen;
      logic tx_hold_empty;
      logic tx_shift_empty;
      logic rx_ninth_bit;
   } status_s;

   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_START = 4'h2,
      TX_DATA = 4'h4,
      TX_STOP = 4'h8
   } tx_state_e;

   typedef enum logic [4:0] {
      RX_IDLE = 5'h01,
      RX_START = 5'h02,
      RX_DATA = 5'h04,
      RX_NINTH = 5'h08,
      RX_STOP = 5'h10
   } rx_state_e;
endpackage

// >>> serial_mp_properties.sv
// Purpose: Port-level properties of the multidrop serial port
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every instance of the port module
`timescale 1ns/1ps
`default_nettype none
module serial_mp_properties (
   input wire logic CLOCK_IN,
   input wire logic RST_B_IN,
   input wire logic CLK_EN_IN,
   input wire serial_mp_pkg::ctrl_s CTRL_IN,
   input wire logic TX_WRITE_IN,
   input wire logic SERIAL_TX_OUT,
   input wire logic [7:0] RX_DATA_OUT,
   input wire serial_mp_pkg::status_s STATUS_OUT,
   input wire logic TX_IRQ_OUT,
   input wire logic RX_IRQ_OUT
);
   // Parity, overrun, framing and break flags
   wire logic errs = |STATUS_OUT[6:3];
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_B_IN);
   tx_irq_a: assert property (TX_IRQ_OUT && !(CLK_EN_IN && TX_WRITE_IN)
      |=> TX_IRQ_OUT) else $error("tx irq dropped without a write");
   hold_take_a: assert property (CLK_EN_IN && TX_WRITE_IN && STATUS_OUT.tx_hold_empty
      |=> !STATUS_OUT.tx_hold_empty) else $error("write not taken");
   shift_load_a: assert property (CLK_EN_IN && !STATUS_OUT.tx_hold_empty
      && STATUS_OUT.tx_shift_empty && CLK_EN_IN |=> STATUS_OUT.tx_hold_empty && !SERIAL_TX_OUT)
      else $error("byte not moved to shifter with start bit");
   stop_high_a: assert property ($rose(STATUS_OUT.tx_shift_empty) |-> SERIAL_TX_OUT)
      else $error("frame ended without high stop");
   irq_data_a: assert property (STATUS_OUT.rx_data_avail_flag && !CTRL_IN.irq_errors_only
      |-> RX_IRQ_OUT) else $error("data without rx irq");
   irq_err_a: assert property (errs |-> RX_IRQ_OUT)
      else $error("error without rx irq");
   irq_quiet_a: assert property (!errs && (CTRL_IN.irq_errors_only
      || !STATUS_OUT.rx_data_avail_flag) |-> !RX_IRQ_OUT) else $error("rx irq without cause");
   break_frame_a: assert property (STATUS_OUT.break_seen |-> STATUS_OUT.framing_error)
      else $error("break without framing error");
   data_hold_a: assert property (!$stable(RX_DATA_OUT) |-> STATUS_OUT.rx_data_avail_flag)
      else $error("rx data changed without avail");
   reset_vals_a: assert property (disable iff (1'b0) !RST_B_IN && CLK_EN_IN
      |=> SERIAL_TX_OUT && TX_IRQ_OUT && !RX_IRQ_OUT) else $error("reset values wrong");
endmodule
bind serial_mp_port serial_mp_properties chk (.CLOCK_IN(CLOCK_IN), .RST_B_IN(RST_B_IN),
   .CLK_EN_IN(CLK_EN_IN), .CTRL_IN(CTRL_IN), .TX_WRITE_IN(TX_WRITE_IN),
   .SERIAL_TX_OUT(SERIAL_TX_OUT), .RX_DATA_OUT(RX_DATA_OUT), .STATUS_OUT(STATUS_OUT),
   .TX_IRQ_OUT(TX_IRQ_OUT), .RX_IRQ_OUT(RX_IRQ_OUT));
`default_nettype wire

// >>> serial_peer.sv
// Purpose: Remote serial peer that sends and decodes frames
// Assumes: Bit time given in system clocks of 8 ns
// Notes: Line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;
   task automatic send(input logic [8:0] v, input bit nine, input bit stop, input int bt);
      line_out = 1'b0;
      #(bt * 8);
      for (int i = 0; i < 9; i++) begin
         if (i < 8 || nine) begin
            line_out = v[i];
            #(bt * 8);
         end
      end
      line_out = stop;
      // A low stop is cut short so the receiver's false start aborts cleanly
      #(stop ? bt * 8 : bt * 6);
      line_out = 1'b1;
      #(bt * 8);
   endtask
   task automatic recv(output logic [9:0] v, input bit nine, input int bt);
      v = '0;
      @(negedge line_in);
      #(bt * 4);
      for (int i = 0; i < 10; i++) begin
         if (i != 8 || nine) begin
            #(bt * 8);
            v[i] = line_in;
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: Self-checking bench for the multidrop serial port
// Assumes: Peer model on the line, expectations from a bench model
// Notes: Clock enable drops once, to show that a write is ignored while frozen
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   serial_mp_pkg::ctrl_s ctrl;
   logic [7:0] tx_data = 8'h00;
   logic tx_write = 1'b0;
   logic rx_read = 1'b0;
   logic err_clear = 1'b0;
   wire logic line_rx;
   wire logic line_tx;
   logic [7:0] rx_data;
   serial_mp_pkg::status_s st;
   logic tx_irq;
   logic rx_irq;
   int n_mismatch = 0;
   int total_checks = 0;
   int bt = 32;
   integer seed = 32'hdf1c0698;
   bit sel = 1'b0;
   bit ovr_exp = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] d;
   always #4 clk = ~clk;
   serial_mp_port dut (.CLOCK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(clk_en), .CTRL_IN(ctrl),
      .TX_DATA_IN(tx_data), .TX_WRITE_IN(tx_write), .RX_READ_IN(rx_read),
      .ERR_CLEAR_IN(err_clear), .SERIAL_RX_IN(line_rx), .SERIAL_TX_OUT(line_tx),
      .RX_DATA_OUT(rx_data), .STATUS_OUT(st), .TX_IRQ_OUT(tx_irq), .RX_IRQ_OUT(rx_irq));
   serial_peer peer (.line_in(line_tx), .line_out(line_rx));
   task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out;
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic tx_case(input bit par, input bit odd, input bit md, input bit flag);
      logic [9:0] got;
      logic [7:0] v;
      v = 8'($random(seed));
      @(negedge clk);
      ctrl.parity_enable = par;
      ctrl.parity_odd = odd;
      ctrl.multidrop_enable = md;
      ctrl.tx_addr_flag_bit = flag;
      tx_data = v;
      tx_write = 1'b1;
      fork
         peer.recv(got, par | md, bt);
         begin
            @(negedge clk);
            tx_write = 1'b0;
         end
      join
      check("tx frame", {1'b1, (par | md) & (md ? flag : ^v ^ odd), v}, got);
   endtask
   task automatic rx_case(input logic [8:0] v, input bit stop);
      bit md;
      bit acc;
      bit perr;
      bit nine;
      md = ctrl.multidrop_enable;
      nine = md | ctrl.parity_enable;
      perr = stop && ctrl.parity_enable && !md && (v[8] !== (^v[7:0] ^ ctrl.parity_odd));
      acc = ctrl.rx_enable && (!md || ctrl.addr_match_scheme != 2'h1 || v[8]);
      // Any received address frame selects or deselects, whatever the scheme
      if (md && v[8] && ctrl.rx_enable)
         sel = (v[7:0] == ctrl.match_address);
      if (md && ctrl.addr_match_scheme[1])
         acc = acc && sel && !(v[8] && ctrl.addr_match_scheme == 2'h2);
      peer.send(v, nine, stop, bt);
      @(negedge clk);
      if (stop) check("rx avail", 10'(acc), 10'(st.rx_data_avail_flag));
      if (stop && acc) check("rx data", 10'(v[7:0]), 10'(rx_data));
      if (stop && acc) check("ninth bit", 10'(v[8] & nine), 10'(st.rx_ninth_bit));
      check("overrun", 10'(ovr_exp && acc), 10'(st.overrun_error));
      check("parity error", 10'(perr), 10'(st.parity_error));
      check("framing error", 10'(!stop), 10'(st.framing_error));
      check("break", 10'(!stop && v == 9'h000), 10'(st.break_seen));
      if (stop) check("rx irq", 10'(perr || acc && !ctrl.irq_errors_only), 10'(rx_irq));
      rx_read = 1'b1;
      err_clear = 1'b1;
      @(negedge clk);
      rx_read = 1'b0;
      err_clear = 1'b0;
      @(negedge clk);
      check("avail after read", 10'h000, 10'(st.rx_data_avail_flag));
   endtask
   initial begin
      ctrl = '0;
      ctrl.baud_divisor_lo = 8'h02; // Exact divisor, zero rate error
      ctrl.rx_enable = 1'b1;
      ctrl.match_address = 8'($random(seed));
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      @(negedge clk);
      check("tx irq", 10'h001, 10'(tx_irq));
      clk_en = 1'b0;
      tx_write = 1'b1;
      @(negedge clk);
      tx_write = 1'b0;
      clk_en = 1'b1;
      @(negedge clk);
      check("frozen write", 10'h003, 10'({tx_irq, line_tx}));
      tx_case(1'b0, 1'b0, 1'b0, 1'b0);
      tx_case(1'b1, 1'b0, 1'b0, 1'b0);
      tx_case(1'b1, 1'b1, 1'b0, 1'b0);
      tx_case(1'b0, 1'b0, 1'b1, 1'b1);
      tx_case(1'b0, 1'b0, 1'b1, 1'b0);
      @(negedge clk);
      ctrl.multidrop_enable = 1'b0;
      ctrl.parity_enable = 1'b1;
      for (int o = 0; o < 2; o++) begin
         ctrl.parity_odd = o[0];
         d = 8'($random(seed));
         rx_case({^d ^ o[0], d}, 1'b1);
         rx_case({~(^d ^ o[0]), d}, 1'b1);
      end
      ctrl.parity_enable = 1'b0;
      rx_case({1'b0, 8'($random(seed))}, 1'b0);
      rx_case(9'h000, 1'b0);
      // First byte left unread, so the second overruns it
      peer.send({1'b0, 8'($random(seed))}, 1'b0, 1'b1, bt);
      ovr_exp = 1'b1;
      rx_case({1'b0, 8'($random(seed))}, 1'b1);
      ovr_exp = 1'b0;
      ctrl.irq_errors_only = 1'b1;
      rx_case({1'b0, 8'($random(seed))}, 1'b1);
      ctrl.irq_errors_only = 1'b0;
      ctrl.rx_enable = 1'b0;
      rx_case({1'b0, 8'($random(seed))}, 1'b1);
      ctrl.rx_enable = 1'b1;
      ctrl.multidrop_enable = 1'b1;
      for (int s = 0; s < 4; s++) begin
         ctrl.addr_match_scheme = 2'(s);
         rx_case({1'b1, ctrl.match_address}, 1'b1);
         rx_case({1'b0, 8'($random(seed))}, 1'b1);
         rx_case({1'b1, ctrl.match_address ^ 8'h01}, 1'b1);
         rx_case({1'b0, 8'($random(seed))}, 1'b1);
      end
      ctrl.baud_divisor_hi = 8'h01;
      ctrl.baud_divisor_lo = 8'h00;
      bt = 16 * 256;
      tx_case(1'b0, 1'b0, 1'b0, 1'b0);
      close_out();
   end
   initial begin
      #(8 * 100000);
      n_mismatch++;
      close_out();
   end
endmodule
`default_nettype wire
